// *** core/vcr_resource_regs.v ***
`timescale 1ns/1ps
`include "vcr_regs.vh"

// Function
// R1: Arbitration capability resets by channel count
// R2: Round robin, WEIGHTED_ROTATION_ARBITRATION, time WEIGHTED_ROTATION_ARBITRATION supported
// R3: Time slot field resets by count
// R4: Loader may override slots and map
// R5: Table offset resets by channel count
// R6: Advanced switching and snoop bits zero
// R7: Each map bit maps one class
// R8: Map bit zero read-only zero
// R9: Load bit applies table, reads zero
// R10: Select accepts 000b, 011b, 100b only
// R11: Writable identifier resets by count
// R12: Enable bit turns channel on
// R13: Table status set on write, cleared
// R14: Reserved bits read zero
module vcr_resource_regs (
  input wire MCLK,
  input wire RESETN,
  input wire [2:0] EXT_CHANNEL_COUNT,
  input wire [11:0] ADDR,
  input wire WR_EN,
  input wire RD_EN,
  input wire [31:0] WDATA,
  input wire LOADER_WR,
  input wire [6:0] LOADER_SLOTS,
  input wire [7:0] LOADER_MAP,
  input wire TABLE_ENTRY_WR,
  output reg [31:0] RDATA,
  output reg RDATA_VALID,
  output reg [7:0] CLASS_MAP,
  output reg [2:0] ARB_SELECT,
  output reg [2:0] CHANNEL_ID,
  output reg CHANNEL_ENABLE,
  output reg TABLE_APPLY,
  output reg TABLE_STATUS
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  reg rst_meta;
  reg rst_n;

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  localparam ph_strap = 2'b01;
  localparam ph_run = 2'b10;

  reg [1:0] phase;
  reg [1:0] next_phase;
  wire strap_done = phase[1];
  wire count_one = (EXT_CHANNEL_COUNT == 3'h1);

  always @* begin
    case (phase)
      ph_strap: next_phase = ph_run;
      ph_run: next_phase = ph_run;
      default: next_phase = ph_strap;
    endcase
  end

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ph_strap;
    end else begin
      phase <= next_phase;
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [7:0] arb_cap;
  reg [6:0] max_slots;
  reg [7:0] table_ofs;
  wire [7:0] map;
  reg [2:0] arb_sel;
  reg [2:0] chan_id;
  reg chan_en;
  reg [2:0] next_sel;

  // Caps word is read-only, so only control writes are decoded
  wire wr_ctrl = WR_EN && (ADDR == `VCR_CTRL_OFFSET);

  always @* begin
    case (WDATA[`VCR_SEL_LSB+2:`VCR_SEL_LSB])
      `VCR_SEL_WRR: next_sel = `VCR_SEL_WRR; // see R10
      `VCR_SEL_TIME_WRR: next_sel = `VCR_SEL_TIME_WRR; // see R2
      default: next_sel = `VCR_SEL_DEFAULT; // see R10
    endcase
  end

  // ----------------------------------------
  // Capability fields
  // ----------------------------------------
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      arb_cap <= `VCR_ARB_CAP_RST0;
      max_slots <= `VCR_SLOTS_RST0;
      table_ofs <= `VCR_TABLE_OFS_RST0;
    end else if (!strap_done) begin
      arb_cap <= count_one ? `VCR_ARB_CAP_RST1 : `VCR_ARB_CAP_RST0; // see R1
      max_slots <= count_one ? `VCR_SLOTS_RST1 : `VCR_SLOTS_RST0; // see R3
      table_ofs <= count_one ? `VCR_TABLE_OFS_RST1 : `VCR_TABLE_OFS_RST0; // see R5
    end else if (LOADER_WR) begin
      max_slots <= LOADER_SLOTS; // see R4
    end
  end

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      arb_sel <= `VCR_SEL_DEFAULT; // see R10
      chan_id <= `VCR_ID_RST0;
      chan_en <= 1'b0; // see R12
    end else if (!strap_done) begin
      chan_id <= count_one ? `VCR_ID_RST1 : `VCR_ID_RST0; // see R11
    end else if (wr_ctrl) begin
      arb_sel <= next_sel; // see R10
      chan_id <= WDATA[`VCR_ID_LSB+2:`VCR_ID_LSB]; // see R11
      chan_en <= WDATA[`VCR_ENABLE_BIT]; // see R12
    end
  end

  // ----------------------------------------
  // Traffic class map, one flop per class 1 to 7
  // ----------------------------------------
  localparam [7:0] map_rst = `VCR_MAP_RST;

  assign map[0] = 1'b0; // see R8

  genvar gi;
  generate
    for (gi = 1; gi < 8; gi = gi + 1) begin : g_map
      reg map_bit;
      always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
          map_bit <= map_rst[gi]; // see R7
        end else if (strap_done && wr_ctrl) begin
          map_bit <= WDATA[`VCR_MAP_LSB+gi]; // see R7
        end else if (strap_done && LOADER_WR) begin
          map_bit <= LOADER_MAP[gi]; // see R4
        end
      end
      assign map[gi] = map_bit;
    end
  endgenerate

  // ----------------------------------------
  // Table load sequencer
  // ----------------------------------------
  wire load_req = wr_ctrl && WDATA[`VCR_LOAD_BIT]; // see R9
  wire table_status_w;
  wire load_done;

  vcr_table_loader u_loader (
    .clk(MCLK),
    .rst_n(rst_n),
    .table_write(TABLE_ENTRY_WR),
    .load_start(load_req),
    .busy(),
    .table_status(table_status_w),
    .load_done(load_done)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [31:0] caps_word;
  wire [31:0] ctrl_word;
  reg [31:0] read_word;

  // Bits 15:14, 13:8 and 23 read zero; see R6 see R14
  assign caps_word = {table_ofs, 1'b0, max_slots, 8'h00, arb_cap};
  // Load bit and reserved ranges read zero; see R9 see R14
  assign ctrl_word = {chan_en, 4'h0, chan_id, 4'h0, arb_sel, 1'b0, 8'h00, map};

  always @* begin
    case (ADDR)
      `VCR_CAPS_OFFSET: read_word = caps_word;
      `VCR_CTRL_OFFSET: read_word = ctrl_word;
      default: read_word = 32'h00000000; // see R14
    endcase
  end

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h00000000;
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= RD_EN;
      if (RD_EN) begin
        RDATA <= read_word;
      end
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      CLASS_MAP <= 8'h00;
      ARB_SELECT <= 3'h0;
      CHANNEL_ID <= 3'h0;
      CHANNEL_ENABLE <= 1'b0;
      TABLE_APPLY <= 1'b0;
      TABLE_STATUS <= 1'b0;
    end else begin
      CLASS_MAP <= map; // see R7
      ARB_SELECT <= arb_sel; // see R10
      CHANNEL_ID <= chan_id; // see R11
      CHANNEL_ENABLE <= chan_en; // see R12
      TABLE_APPLY <= load_done; // see R9
      TABLE_STATUS <= table_status_w; // see R13
    end
  end
endmodule

// *** core/vcr_regs.vh ***
`ifndef VCR_REGS_VH
`define VCR_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VCR_CAPS_OFFSET 12'h15c
`define VCR_CTRL_OFFSET 12'h160

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VCR_ARB_CAP_LSB 0
`define VCR_ADV_SWITCH_BIT 14
`define VCR_SNOOP_REJ_BIT 15
`define VCR_SLOTS_LSB 16
`define VCR_TABLE_OFS_LSB 24
`define VCR_MAP_LSB 0
`define VCR_LOAD_BIT 16
`define VCR_SEL_LSB 17
`define VCR_ID_LSB 24
`define VCR_ENABLE_BIT 31

// ----------------------------------------
// Reset values by extended channel count, and select encodings
// ----------------------------------------
`define VCR_ARB_CAP_RST0 8'h00
`define VCR_ARB_CAP_RST1 8'h19
`define VCR_SLOTS_RST0 7'h00
`define VCR_SLOTS_RST1 7'h7f
`define VCR_TABLE_OFS_RST0 8'h00
`define VCR_TABLE_OFS_RST1 8'h08
`define VCR_MAP_RST 8'h00
`define VCR_ID_RST0 3'h0
`define VCR_ID_RST1 3'h1
`define VCR_SEL_DEFAULT 3'h0
`define VCR_SEL_WRR 3'h3
`define VCR_SEL_TIME_WRR 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define VCR_TABLE_LOAD_CYCLES 4'h8

`endif

// *** core/vcr_table_loader.v ***
`timescale 1ns/1ps
`include "vcr_regs.vh"

// ----------------------------------------
// Table load sequencer and status flag
// ----------------------------------------
module vcr_table_loader (
  input wire clk,
  input wire rst_n,
  input wire table_write,
  input wire load_start,
  output reg busy,
  output reg table_status,
  output reg load_done
);
  reg [3:0] count;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= 4'h0;
      load_done <= 1'b0;
    end else begin
      load_done <= 1'b0;
      if (load_start && !busy) begin
        busy <= 1'b1;
        count <= `VCR_TABLE_LOAD_CYCLES - 4'h1;
      end else if (busy) begin
        if (count == 4'h0) begin
          busy <= 1'b0;
          load_done <= 1'b1;
        end else begin
          count <= count - 4'h1;
        end
      end
    end
  end

  // Set wins over clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_status <= 1'b0;
    end else if (table_write) begin
      table_status <= 1'b1; // see R13
    end else if (busy && count == 4'h0) begin
      table_status <= 1'b0; // see R13
    end
  end
endmodule

// *** tb/vcr_resource_regs_monitor.sv ***
`timescale 1ns/1ps
module vcr_mon (
  input wire MCLK,
  input wire RESETN,
  input wire [11:0] ADDR,
  input wire WR_EN,
  input wire RD_EN,
  input wire [31:0] WDATA,
  input wire TABLE_ENTRY_WR,
  input wire [31:0] RDATA,
  input wire RDATA_VALID,
  input wire [7:0] CLASS_MAP,
  input wire [2:0] ARB_SELECT,
  input wire [2:0] CHANNEL_ID,
  input wire CHANNEL_ENABLE,
  input wire TABLE_APPLY,
  input wire TABLE_STATUS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  wire wc = WR_EN && ADDR == 12'h160;
  wire rc = RD_EN && ADDR == 12'h160;
  sequence s_load;
    wc && WDATA[16];
  endsequence
  sequence s_pulse;
    TABLE_APPLY ##1 !TABLE_APPLY;
  endsequence
  AST_MAP0: assert property (CLASS_MAP[0] == 1'b0)
    else $error("map bit zero set");
  AST_SEL: assert property (ARB_SELECT inside {3'h0, 3'h3, 3'h4})
    else $error("bad select");
  AST_MAP: assert property (wc |=> ##1 CLASS_MAP == {$past(WDATA[7:1], 2), 1'b0})
    else $error("bad map");
  AST_ID: assert property (wc |=> ##1 CHANNEL_ID == $past(WDATA[26:24], 2))
    else $error("bad id");
  AST_EN: assert property (wc |=> ##1 CHANNEL_ENABLE == $past(WDATA[31], 2))
    else $error("bad enable");
  AST_LD: assert property (rc |=> RDATA_VALID && !RDATA[16])
    else $error("load bit read");
  AST_RSV: assert property (rc |=> RDATA[23:20] == 4'h0 && RDATA[15:8] == 8'h00)
    else $error("reserved set");
  AST_CAP: assert property (RD_EN && ADDR == 12'h15c |=> RDATA[15:8] == 8'h00)
    else $error("caps flags set");
  AST_STS: assert property (TABLE_ENTRY_WR |=> ##1 TABLE_STATUS)
    else $error("status not set");
  AST_APPLY: assert property (s_load |-> ##10 s_pulse)
    else $error("no apply");
endmodule

// *** tb/test_vcr_resource_regs.sv ***
`timescale 1ns/1ps
module test_vcr_resource_regs;
  logic MCLK = 0, RESETN = 0, WR_EN = 0, RD_EN = 0, LOADER_WR = 0, TABLE_ENTRY_WR = 0;
  logic [2:0] EXT_CHANNEL_COUNT = 0;
  logic [11:0] ADDR = 0;
  logic [31:0] WDATA = 0;
  logic [6:0] LOADER_SLOTS = 0;
  logic [7:0] LOADER_MAP = 0;
  wire [31:0] RDATA;
  wire [7:0] CLASS_MAP;
  wire [2:0] ARB_SELECT, CHANNEL_ID;
  wire RDATA_VALID, CHANNEL_ENABLE, TABLE_APPLY, TABLE_STATUS;
  int n_mismatch = 0, cmp_count = 0;
  vcr_resource_regs DUT (
    .MCLK(MCLK),
    .RESETN(RESETN),
    .EXT_CHANNEL_COUNT(EXT_CHANNEL_COUNT),
    .ADDR(ADDR),
    .WR_EN(WR_EN),
    .RD_EN(RD_EN),
    .WDATA(WDATA),
    .LOADER_WR(LOADER_WR),
    .LOADER_SLOTS(LOADER_SLOTS),
    .LOADER_MAP(LOADER_MAP),
    .TABLE_ENTRY_WR(TABLE_ENTRY_WR),
    .RDATA(RDATA),
    .RDATA_VALID(RDATA_VALID),
    .CLASS_MAP(CLASS_MAP),
    .ARB_SELECT(ARB_SELECT),
    .CHANNEL_ID(CHANNEL_ID),
    .CHANNEL_ENABLE(CHANNEL_ENABLE),
    .TABLE_APPLY(TABLE_APPLY),
    .TABLE_STATUS(TABLE_STATUS)
  );
  always #50 MCLK = ~MCLK;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic rst(input logic [2:0] c);
    RESETN = 0;
    EXT_CHANNEL_COUNT = c;
    cyc(3);
    RESETN = 1;
    cyc(4);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ADDR = a;
    WDATA = d;
    WR_EN = 1;
    cyc(1);
    WR_EN = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    int i;
    ADDR = a;
    RD_EN = 1;
    cyc(1);
    RD_EN = 0;
    for (i = 0; i < 4 && RDATA_VALID !== 1'b1; i++) cyc(1);
    if (i == 4) begin
      n_mismatch++;
      report_and_stop;
    end
    chk(RDATA, e);
    cyc(1);
  endtask
  task automatic t_reset;
    rst(0);
    rd(12'h15c, 0);
    rd(12'h160, 0);
    rst(1);
    rd(12'h15c, 32'h087f0019);
    rd(12'h160, 32'h01000000);
  endtask
  task automatic t_fields;
    wr(12'h160, 32'hfffeffff);
    chk({CLASS_MAP, ARB_SELECT, CHANNEL_ID, CHANNEL_ENABLE}, 15'h7f0f);
    rd(12'h160, 32'h870000fe);
    wr(12'h160, 0);
    chk(CHANNEL_ENABLE, 0);
  endtask
  task automatic t_sel;
    for (int s = 0; s < 8; s++) begin
      wr(12'h160, s << 17);
      chk(ARB_SELECT, (s == 3 || s == 4) ? s : 0);
      rd(12'h160, (s == 3 || s == 4) ? s << 17 : 0);
    end
  endtask
  task automatic t_load;
    int i;
    TABLE_ENTRY_WR = 1;
    cyc(1);
    TABLE_ENTRY_WR = 0;
    cyc(1);
    chk(TABLE_STATUS, 1);
    wr(12'h160, 32'h00010000);
    for (i = 0; i < 20 && TABLE_APPLY !== 1'b1; i++) cyc(1);
    if (i == 20) begin
      n_mismatch++;
      report_and_stop;
    end
    chk(i, 8);
    chk(TABLE_APPLY, 1);
    chk(TABLE_STATUS, 0);
    rd(12'h160, 0);
  endtask
  task automatic t_ldr;
    LOADER_SLOTS = 7'h05;
    LOADER_MAP = 8'hff;
    LOADER_WR = 1;
    cyc(1);
    LOADER_WR = 0;
    cyc(2);
    rd(12'h15c, 32'h08050019);
    rd(12'h160, 32'h000000fe);
    wr(12'h15c, 0);
    rd(12'h15c, 32'h08050019);
    wr(12'h100, 32'hffffffff);
    rd(12'h100, 0);
  endtask
  initial begin
    t_reset;
    t_fields;
    t_sel;
    t_load;
    t_ldr;
    report_and_stop;
  end
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
bind vcr_resource_regs vcr_mon MON (
  .MCLK(MCLK),
  .RESETN(RESETN),
  .ADDR(ADDR),
  .WR_EN(WR_EN),
  .RD_EN(RD_EN),
  .WDATA(WDATA),
  .TABLE_ENTRY_WR(TABLE_ENTRY_WR),
  .RDATA(RDATA),
  .RDATA_VALID(RDATA_VALID),
  .CLASS_MAP(CLASS_MAP),
  .ARB_SELECT(ARB_SELECT),
  .CHANNEL_ID(CHANNEL_ID),
  .CHANNEL_ENABLE(CHANNEL_ENABLE),
  .TABLE_APPLY(TABLE_APPLY),
  .TABLE_STATUS(TABLE_STATUS)
);
